// [shared/dbdma_cfg.svh]
// Offsets, field positions, reset values and timing counts of the dual-channel DMA host controller.
// Assumes a 10 MHz controller clock; times are in nanoseconds.
`ifndef DBDMA_CFG_SVH
`define DBDMA_CFG_SVH

`define DBDMA_CLK_MHZ 10
// Software register byte offsets on APB
`define DBDMA_A_CTRL 8'h00
`define DBDMA_A_MODE 8'h04
`define DBDMA_A_LADDR 8'h08
`define DBDMA_A_RADDR 8'h0C
`define DBDMA_A_LCFG 8'h10
`define DBDMA_A_RCFG 8'h14
`define DBDMA_A_COUNT 8'h18
`define DBDMA_A_DCMD 8'h1C
`define DBDMA_A_STAT 8'h20
`define DBDMA_A_XWAIT 8'h24
// Control register bits (write-only pulses)
`define DBDMA_CTRL_GO 0
`define DBDMA_CTRL_HALT 1
`define DBDMA_CTRL_RESUME 2
// Mode register fields
`define DBDMA_MODE_LO 0
`define DBDMA_MODE_HI 1
`define DBDMA_MODE_DWR 2
`define DBDMA_MODE_MULTI 3
`define DBDMA_MODE_IRQ 4
`define DBDMA_M_SINGLE 2'h0
`define DBDMA_M_TRACK 2'h1
`define DBDMA_M_NOTRACK 2'h2
// Status register bits
`define DBDMA_ST_BUSY 0
`define DBDMA_ST_DONE 1
`define DBDMA_ST_ERR 2
`define DBDMA_ST_HALTED 3
// Device register indices on the device's own port
`define DBDMA_D_LADDR0 6'h00
`define DBDMA_D_LADDR1 6'h01
`define DBDMA_D_RADDR0 6'h02
`define DBDMA_D_RADDR1 6'h03
`define DBDMA_D_LCFG 6'h04
`define DBDMA_D_RCFG 6'h05
`define DBDMA_D_NSO 6'h06
`define DBDMA_D_SC 6'h07
`define DBDMA_D_OC 6'h08
`define DBDMA_D_DC 6'h09
`define DBDMA_D_STATUS 6'h0A
// Local transfer configuration bits
`define DBDMA_L_ENABLE 0
`define DBDMA_L_WORD 1
`define DBDMA_L_SWAP 2
`define DBDMA_L_SLOW 3
`define DBDMA_L_LONG 4
// Remote transfer configuration bits
`define DBDMA_R_ENABLE 0
`define DBDMA_R_WORD 1
`define DBDMA_R_SLOW 2
`define DBDMA_R_XWAIT 3
`define DBDMA_R_TRACK 4
// Operation command bits
`define DBDMA_OC_IRQ 0
`define DBDMA_OC_RIN 1
`define DBDMA_OC_ROUT 2
// Device status bits
`define DBDMA_DS_ERR 0
`define DBDMA_DS_NEXT 7
// Load sequence
`define DBDMA_STEP_LAST 4'h9
// Device port timing
`define DBDMA_STROBE_NS 300
`define DBDMA_RECOV_NS 100
`define DBDMA_STROBE_CYC ((`DBDMA_STROBE_NS * `DBDMA_CLK_MHZ + 999) / 1000)
`define DBDMA_RECOV_CYC ((`DBDMA_RECOV_NS * `DBDMA_CLK_MHZ + 999) / 1000)
`define DBDMA_XWAIT_RST 8'h04

`endif

// [shared/dbdma_pkg.sv]
// Types shared by the dual-channel DMA host controller and its helpers.
// Assumes dbdma_cfg.svh is on the include path.
`include "dbdma_cfg.svh"

package dbdma_pkg;

  typedef struct packed {
    logic skip;
    logic write;
    logic [5:0] addr;
    logic [7:0] wdata;
  } dbdma_devreq_type;

  typedef enum logic [1:0] {DP_IDLE, DP_SETUP, DP_STROBE, DP_RECOV} dbdma_dp_phase_type;

  typedef struct packed {
    dbdma_dp_phase_type phase;
    logic [3:0] cnt;
    dbdma_devreq_type cmd;
    logic busy;
    logic done;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic oe;
    logic [7:0] d1;
    logic [7:0] d2;
    logic [7:0] d3;
    logic [7:0] rdata;
  } dbdma_dp_type;

  typedef struct packed {
    logic q1;
    logic q2;
    logic q3;
    logic level;
  } dbdma_sync_type;

  typedef enum logic [2:0] {
    ST_IDLE, ST_LOAD, ST_LOAD_WAIT, ST_RUN, ST_STAT_WAIT, ST_OC_WAIT
  } dbdma_state_type;

  typedef struct packed {
    dbdma_state_type st;
    logic [3:0] step;
    logic [1:0] mode;
    logic disk_wr;
    logic multi;
    logic irq_en;
    logic [15:0] laddr;
    logic [15:0] raddr;
    logic [7:0] lcfg;
    logic [7:0] rcfg;
    logic [7:0] sector_operations_counter;
    logic [7:0] sc;
    logic [7:0] dcmd;
    logic [7:0] xwait;
    logic [7:0] dstat;
    logic busy;
    logic done;
    logic err;
    logic halted;
    logic halt_pend;
    logic resume_pend;
    logic req;
    dbdma_devreq_type dreq;
    logic lgnt;
    logic rgnt;
    logic ext_st;
    logic [7:0] wcnt;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dbdma_top_type;

endpackage

// [rtl/dbdma_sync3.sv]
// Three-stage synchroniser for one pin level.
// Assumes the input is asynchronous to i_ref_clk; the level moves once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none

module dbdma_sync3 (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_pin,
  output logic o_level
);

  dbdma_pkg::dbdma_sync_type s_q;
  dbdma_pkg::dbdma_sync_type s_d;

  always_comb begin
    s_d = s_q;
    s_d.q1 = i_pin;
    s_d.q2 = s_q.q1;
    s_d.q3 = s_q.q2;
    if (s_q.q2 == s_q.q3) begin
      s_d.level = s_q.q3;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_level = s_q.level;

endmodule // dbdma_sync3

`default_nettype wire

// [rtl/dbdma_devport.sv]
// Register cycle engine for the device's own microprocessor port.
// Assumes one request at a time, issued only while o_busy is low; read data is stable during the strobe.
`timescale 1ns/10ps
`default_nettype none
`include "dbdma_cfg.svh"

module dbdma_devport #(
  parameter int unsigned STROBE_CYC = `DBDMA_STROBE_CYC,
  parameter int unsigned RECOV_CYC = `DBDMA_RECOV_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_req,
  input wire dbdma_pkg::dbdma_devreq_type i_cmd,
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_rdata,
  output logic o_dev_cs_n,
  output logic o_dev_rd_n,
  output logic o_dev_wr_n,
  output logic [5:0] o_dev_addr,
  output logic [7:0] o_dev_data_o,
  output logic o_dev_data_oe,
  input wire logic [7:0] i_dev_data_i
);

  localparam logic [3:0] STROBE_LAST = 4'(STROBE_CYC - 1);
  localparam logic [3:0] RECOV_LAST = 4'(RECOV_CYC - 1);

  dbdma_pkg::dbdma_dp_type s_q;
  dbdma_pkg::dbdma_dp_type s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    // Bus sampled through three stages like any other pin
    s_d.d1 = i_dev_data_i;
    s_d.d2 = s_q.d1;
    s_d.d3 = s_q.d2;
    case (s_q.phase)
      dbdma_pkg::DP_IDLE: begin
        if (i_req) begin
          s_d.cmd = i_cmd;
          s_d.busy = 1'b1;
          s_d.cs_n = 1'b0;
          s_d.oe = i_cmd.write;
          s_d.phase = dbdma_pkg::DP_SETUP;
        end
      end
      dbdma_pkg::DP_SETUP: begin
        s_d.rd_n = s_q.cmd.write;
        s_d.wr_n = ~s_q.cmd.write;
        s_d.cnt = '0;
        s_d.phase = dbdma_pkg::DP_STROBE;
      end
      dbdma_pkg::DP_STROBE: begin
        s_d.cnt = s_q.cnt + 4'h1;
        // Extra strobe cycle while the read bus is still settling
        if (s_q.cnt >= STROBE_LAST && (s_q.cmd.write || s_q.d2 == s_q.d3)) begin
          s_d.rdata = s_q.d3;
          s_d.rd_n = 1'b1;
          s_d.wr_n = 1'b1;
          s_d.cnt = '0;
          s_d.phase = dbdma_pkg::DP_RECOV;
        end
      end
      dbdma_pkg::DP_RECOV: begin
        s_d.cs_n = 1'b1;
        s_d.oe = 1'b0;
        s_d.cnt = s_q.cnt + 4'h1;
        if (s_q.cnt >= RECOV_LAST) begin
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
          s_d.phase = dbdma_pkg::DP_IDLE;
        end
      end
      default: begin
        s_d.phase = dbdma_pkg::DP_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q <= '0;
      s_q.cs_n <= 1'b1;
      s_q.rd_n <= 1'b1;
      s_q.wr_n <= 1'b1;
      s_q.phase <= dbdma_pkg::DP_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_busy = s_q.busy;
  assign o_done = s_q.done;
  assign o_rdata = s_q.rdata;
  assign o_dev_cs_n = s_q.cs_n;
  assign o_dev_rd_n = s_q.rd_n;
  assign o_dev_wr_n = s_q.wr_n;
  assign o_dev_addr = s_q.cmd.addr;
  assign o_dev_data_o = s_q.cmd.wdata;
  assign o_dev_data_oe = s_q.oe;

endmodule // dbdma_devport

`default_nettype wire

// [rtl/dbdma_host.sv]
// Host controller for a disk-buffer dual-channel DMA device: programs it, arbitrates its bus, reads status.
// Assumes software on APB, the device register port on the dev pins, and asynchronous device pins.
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "dbdma_cfg.svh"

// Functional notes
// - Controller holds external status asserted to stretch a remote cycle when enabled.
// - Controller loads local config fully before a local-only operation.
// - Device raises local request; controller grants the bus to it.
// - On interrupt, controller reads status; next-command flag marks completion.
// - Tracking needs both channel enables and tracking bit set by controller.
// - Tracking needs long address bit cleared by controller.
// - Tracking loads both address counters with the same buffer start address.
// - Multi-sector loads operations and sector counters; single loads only sector counter.
// - Controller grants bus to whichever local or remote request is raised.
// - Non-tracking channels run independently; controller keeps buffers from overlapping (not checked here: raddr and laddr are loaded as software wrote them).
// - Interrupt enable written in operation command before the drive command.
module dbdma_host (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata,
  output logic o_busy,
  output logic o_dev_cs_n,
  output logic o_dev_rd_n,
  output logic o_dev_wr_n,
  output logic [5:0] o_dev_addr,
  output logic [7:0] o_dev_data_o,
  output logic o_dev_data_oe,
  input wire logic [7:0] i_dev_data_i,
  input wire logic i_dev_irq,
  input wire logic i_local_bus_request,
  input wire logic i_remote_bus_request,
  output logic o_local_grant,
  output logic o_remote_grant,
  output logic o_ext_status
);

  dbdma_pkg::dbdma_top_type s_q;
  dbdma_pkg::dbdma_top_type s_d;

  logic dp_busy;
  logic dp_done;
  logic [7:0] dp_rdata;
  logic irq_lvl;
  logic lrq_lvl;
  logic rrq_lvl;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and device port

  dbdma_sync3 u_sync_irq (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_pin(i_dev_irq),
    .o_level(irq_lvl)
  );

  dbdma_sync3 u_sync_lrq (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_pin(i_local_bus_request),
    .o_level(lrq_lvl)
  );

  dbdma_sync3 u_sync_rrq (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_pin(i_remote_bus_request),
    .o_level(rrq_lvl)
  );

  dbdma_devport u_devport (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_req(s_q.req),
    .i_cmd(s_q.dreq),
    .o_busy(dp_busy),
    .o_done(dp_done),
    .o_rdata(dp_rdata),
    .o_dev_cs_n(o_dev_cs_n),
    .o_dev_rd_n(o_dev_rd_n),
    .o_dev_wr_n(o_dev_wr_n),
    .o_dev_addr(o_dev_addr),
    .o_dev_data_o(o_dev_data_o),
    .o_dev_data_oe(o_dev_data_oe),
    .i_dev_data_i(i_dev_data_i)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Operation command value for the current mode and direction

  function automatic logic [7:0] oc_value(input dbdma_pkg::dbdma_top_type s);
    logic [7:0] v;
    v = 8'h00;
    v[`DBDMA_OC_IRQ] = s.irq_en;
    if (s.mode != `DBDMA_M_SINGLE) begin
      // Disk write fills the buffer from the system port first
      v[`DBDMA_OC_RIN] = s.disk_wr;
      v[`DBDMA_OC_ROUT] = ~s.disk_wr;
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Load sequence: address bytes, configs, counters, command word, drive command last

  function automatic dbdma_pkg::dbdma_devreq_type load_step(input dbdma_pkg::dbdma_top_type s);
    dbdma_pkg::dbdma_devreq_type r;
    logic [15:0] ra;
    logic [7:0] lc;
    logic [7:0] rc;
    logic single;
    r = '0;
    r.write = 1'b1;
    single = (s.mode == `DBDMA_M_SINGLE);
    ra = (s.mode == `DBDMA_M_TRACK) ? s.laddr : s.raddr;
    lc = s.lcfg;
    lc[`DBDMA_L_ENABLE] = 1'b1;
    rc = s.rcfg;
    if (s.mode != `DBDMA_M_SINGLE) begin
      rc[`DBDMA_R_ENABLE] = 1'b1;
    end
    rc[`DBDMA_R_TRACK] = (s.mode == `DBDMA_M_TRACK);
    if (s.mode == `DBDMA_M_TRACK) begin
      lc[`DBDMA_L_LONG] = 1'b0;
    end
    case (s.step)
      4'h0: begin
        r.addr = `DBDMA_D_LADDR0;
        r.wdata = s.laddr[7:0];
      end
      4'h1: begin
        r.addr = `DBDMA_D_LADDR1;
        r.wdata = s.laddr[15:8];
      end
      4'h2: begin
        r.addr = `DBDMA_D_RADDR0;
        r.wdata = ra[7:0];
        r.skip = single;
      end
      4'h3: begin
        r.addr = `DBDMA_D_RADDR1;
        r.wdata = ra[15:8];
        r.skip = single;
      end
      4'h4: begin
        r.addr = `DBDMA_D_LCFG;
        r.wdata = lc;
      end
      4'h5: begin
        r.addr = `DBDMA_D_RCFG;
        r.wdata = rc;
        r.skip = single;
      end
      4'h6: begin
        r.addr = `DBDMA_D_NSO;
        r.wdata = s.sector_operations_counter;
        r.skip = ~s.multi;
      end
      4'h7: begin
        r.addr = `DBDMA_D_SC;
        r.wdata = s.sc;
      end
      4'h8: begin
        r.addr = `DBDMA_D_OC;
        r.wdata = oc_value(s);
      end
      default: begin
        r.addr = `DBDMA_D_DC;
        r.wdata = s.dcmd;
      end
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic acc;
    logic wr;
    logic [7:0] ocw;
    dbdma_pkg::dbdma_devreq_type ls;
    s_d = s_q;
    s_d.req = 1'b0;
    ocw = oc_value(s_q);
    ls = load_step(s_q);
    acc = i_psel & i_penable & s_q.pready;
    wr = acc & i_pwrite;

    // APB slave: one wait state, answer registered
    s_d.pready = i_psel & i_penable & ~s_q.pready;
    s_d.pslverr = 1'b0;
    s_d.prdata = 32'h00000000;
    if (i_psel & i_penable & ~s_q.pready) begin
      case (i_paddr)
        `DBDMA_A_CTRL: s_d.prdata = 32'h00000000;
        `DBDMA_A_MODE: s_d.prdata = {27'h0000000, s_q.irq_en, s_q.multi, s_q.disk_wr, s_q.mode};
        `DBDMA_A_LADDR: s_d.prdata = {16'h0000, s_q.laddr};
        `DBDMA_A_RADDR: s_d.prdata = {16'h0000, s_q.raddr};
        `DBDMA_A_LCFG: s_d.prdata = {24'h000000, s_q.lcfg};
        `DBDMA_A_RCFG: s_d.prdata = {24'h000000, s_q.rcfg};
        `DBDMA_A_COUNT: s_d.prdata = {16'h0000, s_q.sc, s_q.sector_operations_counter};
        `DBDMA_A_DCMD: s_d.prdata = {24'h000000, s_q.dcmd};
        `DBDMA_A_STAT: s_d.prdata = {16'h0000, s_q.dstat, 4'h0, s_q.halted, s_q.err, s_q.done, s_q.busy};
        `DBDMA_A_XWAIT: s_d.prdata = {24'h000000, s_q.xwait};
        default: s_d.pslverr = 1'b1;
      endcase
    end

    // Setup registers are frozen while an operation runs
    if (wr && !s_q.busy) begin
      case (i_paddr)
        `DBDMA_A_MODE: begin
          s_d.mode = i_pwdata[`DBDMA_MODE_HI:`DBDMA_MODE_LO];
          s_d.disk_wr = i_pwdata[`DBDMA_MODE_DWR];
          s_d.multi = i_pwdata[`DBDMA_MODE_MULTI];
          s_d.irq_en = i_pwdata[`DBDMA_MODE_IRQ];
        end
        `DBDMA_A_LADDR: s_d.laddr = i_pwdata[15:0];
        `DBDMA_A_RADDR: s_d.raddr = i_pwdata[15:0];
        `DBDMA_A_LCFG: s_d.lcfg = i_pwdata[7:0];
        `DBDMA_A_RCFG: s_d.rcfg = i_pwdata[7:0];
        `DBDMA_A_COUNT: begin
          s_d.sector_operations_counter = i_pwdata[7:0];
          s_d.sc = i_pwdata[15:8];
        end
        `DBDMA_A_DCMD: s_d.dcmd = i_pwdata[7:0];
        `DBDMA_A_XWAIT: s_d.xwait = i_pwdata[7:0];
        default: begin
        end
      endcase
    end
    // Write one to clear; a new result landing this cycle overrides it below
    if (wr && i_paddr == `DBDMA_A_STAT) begin
      if (i_pwdata[`DBDMA_ST_DONE]) s_d.done = 1'b0;
      if (i_pwdata[`DBDMA_ST_ERR]) s_d.err = 1'b0;
    end
    if (wr && i_paddr == `DBDMA_A_CTRL) begin
      if (i_pwdata[`DBDMA_CTRL_GO] && !s_q.busy) begin
        s_d.busy = 1'b1;
        s_d.halted = 1'b0;
        s_d.step = 4'h0;
        s_d.st = dbdma_pkg::ST_LOAD;
      end
      if (i_pwdata[`DBDMA_CTRL_HALT] && s_q.busy && s_q.mode == `DBDMA_M_NOTRACK) begin
        s_d.halt_pend = 1'b1;
      end
      if (i_pwdata[`DBDMA_CTRL_RESUME] && s_q.halted) begin
        s_d.resume_pend = 1'b1;
      end
    end

    // Bus arbitration: hold a grant until its request drops
    if (s_q.lgnt) begin
      s_d.lgnt = lrq_lvl;
    end else if (s_q.rgnt) begin
      s_d.rgnt = rrq_lvl;
    end else if (lrq_lvl) begin
      s_d.lgnt = 1'b1;
    end else if (rrq_lvl) begin
      s_d.rgnt = 1'b1;
      s_d.wcnt = s_q.xwait;
    end
    // External status stretches each remote cycle by the programmed count
    s_d.ext_st = 1'b0;
    if (s_q.rgnt && s_d.rgnt && s_q.rcfg[`DBDMA_R_XWAIT] && s_q.wcnt != 8'h00) begin
      s_d.ext_st = 1'b1;
      s_d.wcnt = s_q.wcnt - 8'h01;
    end

    case (s_q.st)
      dbdma_pkg::ST_IDLE: begin
      end
      dbdma_pkg::ST_LOAD: begin
        if (ls.skip) begin
          s_d.step = s_q.step + 4'h1;
        end else if (!dp_busy) begin
          s_d.dreq = ls;
          s_d.req = 1'b1;
          s_d.st = dbdma_pkg::ST_LOAD_WAIT;
        end
      end
      dbdma_pkg::ST_LOAD_WAIT: begin
        if (dp_done) begin
          s_d.step = s_q.step + 4'h1;
          s_d.st = (s_q.step == `DBDMA_STEP_LAST) ? dbdma_pkg::ST_RUN : dbdma_pkg::ST_LOAD;
        end
      end
      dbdma_pkg::ST_RUN: begin
        if (irq_lvl && !dp_busy) begin
          s_d.dreq = '0;
          s_d.dreq.addr = `DBDMA_D_STATUS;
          s_d.req = 1'b1;
          s_d.st = dbdma_pkg::ST_STAT_WAIT;
        end else if ((s_q.halt_pend || s_q.resume_pend) && !dp_busy) begin
          s_d.dreq = '0;
          s_d.dreq.write = 1'b1;
          s_d.dreq.addr = `DBDMA_D_OC;
          // Both start bits stop the remote channel; the original word restarts it
          s_d.dreq.wdata = s_q.halt_pend ? (ocw | 8'h06) : ocw;
          s_d.halted = s_q.halt_pend;
          s_d.halt_pend = 1'b0;
          s_d.resume_pend = 1'b0;
          s_d.req = 1'b1;
          s_d.st = dbdma_pkg::ST_OC_WAIT;
        end
      end
      dbdma_pkg::ST_STAT_WAIT: begin
        if (dp_done) begin
          s_d.dstat = dp_rdata;
          s_d.st = dbdma_pkg::ST_RUN;
          if (dp_rdata[`DBDMA_DS_ERR]) begin
            s_d.err = 1'b1;
            s_d.busy = 1'b0;
            s_d.st = dbdma_pkg::ST_IDLE;
          end else if (dp_rdata[`DBDMA_DS_NEXT]) begin
            s_d.done = 1'b1;
            s_d.busy = 1'b0;
            s_d.st = dbdma_pkg::ST_IDLE;
          end
        end
      end
      dbdma_pkg::ST_OC_WAIT: begin
        if (dp_done) begin
          s_d.st = dbdma_pkg::ST_RUN;
        end
      end
      default: begin
        s_d.st = dbdma_pkg::ST_IDLE;
      end
    endcase
    if (!s_d.busy) begin
      s_d.halt_pend = 1'b0;
      s_d.resume_pend = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q <= '0;
      s_q.st <= dbdma_pkg::ST_IDLE;
      s_q.xwait <= `DBDMA_XWAIT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_pready = s_q.pready;
  assign o_pslverr = s_q.pslverr;
  assign o_prdata = s_q.prdata;
  assign o_busy = s_q.busy;
  assign o_local_grant = s_q.lgnt;
  assign o_remote_grant = s_q.rgnt;
  assign o_ext_status = s_q.ext_st;

endmodule // dbdma_host

`default_nettype wire

// [bench/dbdma_host_monitor.sv]
// Checker on the controller's device port and bus grants.
// Assumes it is bound into dbdma_host.
`timescale 1ns/10ps
`default_nettype none
module dbdma_host_monitor (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_local_bus_request,
  input wire logic i_remote_bus_request,
  input wire logic o_local_grant,
  input wire logic o_remote_grant,
  input wire logic o_ext_status,
  input wire logic o_dev_cs_n,
  input wire logic o_dev_wr_n,
  input wire logic o_dev_rd_n,
  input wire logic [5:0] o_dev_addr,
  input wire logic [7:0] o_dev_data_o,
  input wire logic o_dev_data_oe
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  lgnt_cause_a:
    assert property ($rose(o_local_grant) |-> $past(i_local_bus_request, 2)) else $error("local grant unasked");
  lgnt_release_a:
    assert property ($fell(i_local_bus_request) |-> ##[1:8] !o_local_grant) else $error("local grant kept");
  rgnt_cause_a:
    assert property ($rose(o_remote_grant) |-> $past(i_remote_bus_request, 2)) else $error("remote grant unasked");
  grant_onehot_a:
    assert property (!(o_local_grant && o_remote_grant)) else $error("two grants");
  xwait_grant_a:
    assert property (o_ext_status |-> o_remote_grant) else $error("stretch without grant");
  strobe_select_a:
    assert property (!(o_dev_rd_n && o_dev_wr_n) |-> !o_dev_cs_n) else $error("strobe unselected");
  strobe_len_a:
    assert property ($fell(o_dev_wr_n) |-> !o_dev_wr_n [*3] ##1 o_dev_wr_n) else $error("write strobe length");
  write_drive_a:
    assert property (!o_dev_wr_n |-> o_dev_data_oe && $stable(o_dev_data_o) && $stable(o_dev_addr))
      else $error("write data moved");
endmodule // dbdma_host_monitor
//////////////////////////////
bind dbdma_host dbdma_host_monitor dbdma_host_monitor_inst (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
  .i_local_bus_request(i_local_bus_request), .i_remote_bus_request(i_remote_bus_request),
  .o_local_grant(o_local_grant), .o_remote_grant(o_remote_grant), .o_ext_status(o_ext_status),
  .o_dev_cs_n(o_dev_cs_n), .o_dev_wr_n(o_dev_wr_n), .o_dev_rd_n(o_dev_rd_n), .o_dev_addr(o_dev_addr),
  .o_dev_data_o(o_dev_data_o), .o_dev_data_oe(o_dev_data_oe));
`default_nettype wire

// [bench/dbdma_dev_model.sv]
// Behavioural device: register port, bus requests, completion interrupt.
// Assumes strobes synchronous to i_ref_clk; i_lat sets how slow it answers.
`timescale 1ns/10ps
`default_nettype none
module dbdma_dev_model (
  input wire logic i_ref_clk,
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [5:0] i_addr,
  input wire logic [7:0] i_data,
  input wire logic i_lgnt,
  input wire logic i_rgnt,
  input wire logic [7:0] i_lat,
  input wire logic i_fail,
  output logic [7:0] o_data,
  output logic o_irq = 1'b0,
  output logic o_lrq = 1'b0,
  output logic o_rrq = 1'b0
);
  logic [7:0] regs [0:15] = '{default: 8'h00};
  logic [7:0] stat = 8'h00;
  logic [7:0] last = 8'h00;
  logic go = 1'b0;
  logic rd;
  assign rd = !i_cs_n && !i_rd_n;
  // Released bus shows the inverse of the last value, never a held copy
  assign o_data = rd ? (i_addr == 6'h0A ? stat : regs[i_addr[3:0]]) : ~last;
  always @(posedge i_ref_clk) begin
    if (!i_cs_n && !i_wr_n) regs[i_addr[3:0]] <= i_data;
    if (rd) last <= o_data;
    go <= !i_cs_n && !i_wr_n && i_addr == 6'h09;
  end
  task automatic grab(input logic r);
    int n;
    if (r) o_rrq <= 1'b1;
    else o_lrq <= 1'b1;
    for (n = 0; n < 99 && !(r ? i_rgnt : i_lgnt); n++) @(posedge i_ref_clk);
    repeat (regs[r ? 5 : 4][r ? 2 : 3] ? 5 : 4) @(posedge i_ref_clk);
    repeat (i_lat) @(posedge i_ref_clk);
    o_lrq <= 1'b0;
    o_rrq <= 1'b0;
    repeat (8) @(posedge i_ref_clk);
  endtask
  initial begin : flow
    int n;
    forever begin
      @(posedge go);
      stat <= 8'h00;
      repeat (i_lat) @(posedge i_ref_clk);
      // Destination asks only after a full source sector, so the difference count is never zero then
      grab(1'b0);
      if (regs[5][0]) grab(1'b1);
      stat <= i_fail ? 8'h01 : 8'h80;
      o_irq <= regs[8][0];
      for (n = 0; n < 999 && !(rd && i_addr == 6'h0A); n++) @(posedge i_ref_clk);
      o_irq <= 1'b0;
    end
  end
endmodule // dbdma_dev_model
`default_nettype wire

// [bench/dbdma_host_tb_top.sv]
// Self-checking bench: APB call sequences against the controller and the device model.
// Assumes dbdma_pkg and the design files are compiled first.
`timescale 1ns/10ps
`default_nettype none
module dbdma_host_tb_top;
  logic clk = 1'b0;
  logic arst_n, psel, pen, pwr, pready, pslverr, busy, cs_n, rd_n, wr_n, irq, local_bus_request, remote_bus_request, lgnt, rgnt, xst;
  logic fail, slv;
  logic [7:0] paddr, dout, din, lat;
  logic [5:0] daddr;
  logic [31:0] pwdata, prdata;
  logic [31:0] xcnt = 32'h0;
  logic [31:0] xrun = 32'h0;
  int err_count = 0;
  int check_count = 0;
  always #50 clk = ~clk;
  dbdma_host dbdma_host_inst (.i_ref_clk(clk), .i_arst_n(arst_n), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_prdata(prdata), .o_busy(busy), .o_dev_cs_n(cs_n), .o_dev_rd_n(rd_n), .o_dev_wr_n(wr_n),
    .o_dev_addr(daddr), .o_dev_data_o(dout), .o_dev_data_oe(), .i_dev_data_i(din), .i_dev_irq(irq),
    .i_local_bus_request(local_bus_request), .i_remote_bus_request(remote_bus_request), .o_local_grant(lgnt), .o_remote_grant(rgnt),
    .o_ext_status(xst));
  dbdma_dev_model dbdma_dev_model_inst (.i_ref_clk(clk), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n),
    .i_addr(daddr), .i_data(dout), .i_lgnt(lgnt), .i_rgnt(rgnt), .i_lat(lat), .i_fail(fail),
    .o_data(din), .o_irq(irq), .o_lrq(local_bus_request), .o_rrq(remote_bus_request));
  always @(posedge clk) begin
    if (xst === 1'b1) xcnt <= xcnt + 1;
    else if (xcnt != 0) begin
      xrun <= xcnt;
      xcnt <= 0;
    end
  end
  //////////////////////////////
  task automatic final_report;
    if (err_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic hang;
    err_count++;
    final_report;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) hang;
    q = prdata;
    slv = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    check(q & m, e);
  endtask
  // Polls because device cycles lag the APB write by an amount set by the load sequence and device port cycles
  task automatic dv(input int i, input logic [7:0] e);
    int n;
    for (n = 0; n < 300 && dbdma_dev_model_inst.regs[i] !== e; n++) @(posedge clk);
    check({24'h0, dbdma_dev_model_inst.regs[i]}, {24'h0, e});
  endtask
  task automatic idle;
    int n;
    for (n = 0; n < 20 && busy !== 1'b1; n++) @(posedge clk);
    for (n = 0; n < 3000 && busy !== 1'b0; n++) @(posedge clk);
    if (n == 3000) hang;
  endtask
  //////////////////////////////
  initial begin : main
    arst_n = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lat = 8'h08;
    fail = 1'b0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rdc(8'h24, 32'hFFFFFFFF, 32'h4);
    rdc(8'h30, 32'hFFFFFFFF, 32'h0);
    check({31'h0, slv}, 32'h1);
    wr(8'h08, 32'h1234);
    wr(8'h10, 32'h0A);
    wr(8'h18, 32'h0100);
    wr(8'h04, 32'h10);
    wr(8'h1C, 32'h5A);
    wr(8'h00, 32'h1);
    idle;
    dv(0, 8'h34);
    dv(1, 8'h12);
    dv(4, 8'h0B);
    dv(5, 8'h00);
    dv(6, 8'h00);
    dv(7, 8'h01);
    dv(8, 8'h01);
    dv(9, 8'h5A);
    rdc(8'h20, 32'hFFFFFFFF, 32'h8002);
    wr(8'h20, 32'h6);
    wr(8'h08, 32'h4000);
    wr(8'h0C, 32'h7777);
    wr(8'h10, 32'h11);
    wr(8'h14, 32'h0);
    wr(8'h18, 32'h0203);
    wr(8'h04, 32'h19);
    wr(8'h00, 32'h1);
    idle;
    dv(2, 8'h00);
    dv(3, 8'h40);
    dv(4, 8'h01);
    dv(5, 8'h11);
    dv(6, 8'h03);
    dv(8, 8'h05);
    rdc(8'h20, 32'hFFFFFFFF, 32'h8002);
    wr(8'h20, 32'h6);
    lat <= 8'h96;
    wr(8'h24, 32'h2);
    wr(8'h0C, 32'h2000);
    wr(8'h14, 32'h08);
    wr(8'h1C, 32'h33);
    wr(8'h04, 32'h16);
    wr(8'h00, 32'h1);
    dv(9, 8'h33);
    wr(8'h00, 32'h2);
    dv(8, 8'h07);
    rdc(8'h20, 32'hFF, 32'h09);
    wr(8'h00, 32'h4);
    dv(8, 8'h03);
    idle;
    dv(3, 8'h20);
    dv(1, 8'h40);
    dv(5, 8'h09);
    check(xrun, 32'h2);
    wr(8'h20, 32'h6);
    fail <= 1'b1;
    lat <= 8'h04;
    wr(8'h04, 32'h10);
    wr(8'h00, 32'h1);
    idle;
    rdc(8'h20, 32'hFFFFFFFF, 32'h0104);
    final_report;
  end
endmodule // dbdma_host_tb_top
`default_nettype wire
